// *** ocfr_pkg.sv ***
// package: command code, field layout, reset value and timing for the over-current response
package ocfr_pkg;
  localparam logic [7:0] CMD_OC_ACTION = 8'h47;
  localparam logic [7:0] OC_ACTION_RESET = 8'h00;
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // default delay unit in microseconds and its cycle count at 25 MHz
  localparam int DELAY_UNIT_US = 10;
  localparam int CLOCK_MHZ = 25;
  localparam int UNIT_CYCLES = DELAY_UNIT_US * CLOCK_MHZ;
  typedef enum logic [1:0] {
    RESP_IGNORE = 2'h0,
    RESP_RIDE_THROUGH = 2'h1,
    RESP_SHUTDOWN = 2'h2,
    RESP_FOLLOW = 2'h3
  } resp_e;
  typedef struct packed {
    logic [1:0] response;
    logic [2:0] retries;
    logic [2:0] delay;
  } oc_action_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } cmd_req_s;
endpackage

// *** overcurrent_fault_response.sv ***
// over-current fault response controller with its command register
module overcurrent_fault_response #(
  parameter int UNIT_CYC = ocfr_pkg::UNIT_CYCLES,
  parameter int RESTART_CYC = 16
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire ocfr_pkg::cmd_req_s cmd_in,
  output logic [7:0] rdata_out,
  output logic cmd_ack_out,
  input wire logic oc_fault_in,
  input wire logic enable_cmd_in,
  input wire logic bias_ok_in,
  input wire logic other_fault_in,
  input wire logic clear_fault_in,
  output logic output_enable_out,
  output logic fault_latched_out,
  output logic [2:0] attempts_out
);
  import ocfr_pkg::*;

  typedef enum logic [2:0] {RUN, RIDE, OFF_WAIT, RESTART, HOLD_OFF, LATCHED} st_e;

  // power-of-two decode of the delay field
  function automatic logic [31:0] delay_cycles(input logic [2:0] code);
    delay_cycles = (32'h1 << code) * 32'(UNIT_CYC);
  endfunction

  logic [1:0] flt_sync_r;
  oc_action_s cfg_r;
  oc_action_s cfg_nxt;
  st_e st_r;
  st_e st_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic [2:0] att_r;
  logic [2:0] att_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;

  // command decode: only the response command is acknowledged
  wire cmd_hit = cmd_in.cmd == CMD_OC_ACTION;
  wire wr_hit = cmd_in.wr && cmd_hit;
  wire rd_hit = cmd_in.rd && cmd_hit;
  wire rd_other = cmd_in.rd && !cmd_hit;
  assign ack_nxt = wr_hit || rd_hit;
  assign cfg_nxt = wr_hit ? oc_action_s'(cmd_in.wdata) : cfg_r;
  // a read of any other command returns zero
  assign rdata_nxt = rd_hit ? 8'(cfg_r) : (rd_other ? 8'h00 : rdata_r);

  // fault handling conditions
  wire fault = flt_sync_r[1];
  wire stop_all = !enable_cmd_in || !bias_ok_in || other_fault_in;
  wire [31:0] spacing = delay_cycles(cfg_r.delay);
  wire endless = cfg_r.retries == RETRY_FOREVER;
  wire retries_left = endless || (att_r < cfg_r.retries);
  // timer counts down to zero and holds there
  wire tmr_done = tmr_r == 32'h0;
  wire [31:0] tmr_dec = tmr_done ? 32'h0 : tmr_r - 32'h1;
  wire [2:0] att_inc = endless ? att_r : att_r + 3'h1;

  // two-flop synchroniser for the asynchronous fault level
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flt_sync_r <= 2'h0;
    end else begin
      flt_sync_r <= {flt_sync_r[0], oc_fault_in};
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_r <= oc_action_s'(OC_ACTION_RESET);
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // decide where a confirmed fault leads under the retry field
  function automatic st_e after_fault(input logic more);
    if (cfg_r.retries == RETRY_NONE) begin
      after_fault = LATCHED;
    end else if (more) begin
      after_fault = OFF_WAIT;
    end else begin
      after_fault = LATCHED;
    end
  endfunction

  // response state machine
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_dec;
    att_nxt = att_r;
    unique case (st_r)
      RUN: begin
        if (clear_fault_in) begin
          att_nxt = 3'h0;
        end
        if (fault) begin
          unique case (resp_e'(cfg_r.response))
            RESP_IGNORE: st_nxt = RUN;
            RESP_RIDE_THROUGH: begin
              st_nxt = RIDE;
              tmr_nxt = spacing;
            end
            RESP_SHUTDOWN: begin
              st_nxt = after_fault(retries_left);
              tmr_nxt = spacing;
            end
            RESP_FOLLOW: st_nxt = HOLD_OFF;
          endcase
        end
      end
      RIDE: begin
        if (!fault) begin
          st_nxt = RUN;
        end else if (tmr_done) begin
          st_nxt = after_fault(retries_left);
          tmr_nxt = spacing;
        end
      end
      OFF_WAIT: begin
        if (stop_all) begin
          st_nxt = LATCHED;
        end else if (tmr_done) begin
          st_nxt = RESTART;
          tmr_nxt = 32'(RESTART_CYC);
          att_nxt = att_inc;
        end
      end
      RESTART: begin
        if (stop_all) begin
          st_nxt = LATCHED;
        end else if (fault) begin
          // next attempt starts one spacing after the fault that ends this one
          st_nxt = after_fault(retries_left);
          tmr_nxt = spacing;
        end else if (tmr_done) begin
          st_nxt = RUN;
          att_nxt = 3'h0;
        end
      end
      HOLD_OFF: begin
        if (!fault) begin
          st_nxt = RUN;
        end
      end
      LATCHED: begin
        if (clear_fault_in) begin
          st_nxt = RUN;
          att_nxt = 3'h0;
        end
      end
      default: st_nxt = LATCHED;
    endcase
  end

  // state, timer and attempt registers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tmr_r <= 32'h0;
    end else begin
      tmr_r <= tmr_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      att_r <= 3'h0;
    end else begin
      att_r <= att_nxt;
    end
  end

  // output is on while running, riding through or trying a restart
  wire on_state = (st_r == RUN) || (st_r == RIDE) || (st_r == RESTART);
  assign output_enable_out = on_state;
  assign fault_latched_out = st_r == LATCHED;
  assign attempts_out = att_r;
  assign rdata_out = rdata_r;
  assign cmd_ack_out = ack_r;
endmodule

// *** ocfr_properties.sv ***
// checker: command and fault response properties
module ocfr_properties (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire ocfr_pkg::cmd_req_s cmd_in,
  input wire logic cmd_ack_out,
  input wire logic oc_fault_in,
  input wire logic clear_fault_in,
  input wire logic output_enable_out,
  input wire logic fault_latched_out
);
  import ocfr_pkg::*;
  logic [7:0] cfg_r;
  wire hit = (cmd_in.wr | cmd_in.rd) & (cmd_in.cmd == CMD_OC_ACTION);
  wire [1:0] rsp = cfg_r[7:6];
  wire on = output_enable_out;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) cfg_r <= OC_ACTION_RESET;
    else if (hit & cmd_in.wr) cfg_r <= cmd_in.wdata;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_ack_on_hit: assert property (hit |=> cmd_ack_out) else $error("no ack");
  a_no_stray: assert property (!hit |=> !cmd_ack_out) else $error("stray ack");
  a_shut_fast: assert property (rsp == 2'h2 && $rose(oc_fault_in) |-> ##[1:3] !on)
    else $error("no shutdown");
  a_follow_off: assert property ((rsp == 2'h3 && oc_fault_in)[*5] |-> !on)
    else $error("on in fault");
  a_follow_on: assert property ((rsp == 2'h3 && !oc_fault_in && !fault_latched_out)[*5] |-> on)
    else $error("not resumed");
  a_ignore_on: assert property (rsp == 2'h0 && on |=> on) else $error("ignore off");
  a_latch_off: assert property (fault_latched_out && !clear_fault_in |=> fault_latched_out)
    else $error("latch lost");
  a_clear_gone: assert property (fault_latched_out && clear_fault_in |=> !fault_latched_out)
    else $error("clear");
  c_follow: cover property (rsp == 2'h3 && !on);
  c_latch: cover property ($rose(fault_latched_out));
  c_write: cover property (hit && cmd_in.wr);
endmodule
bind overcurrent_fault_response ocfr_properties ocfr_properties_i (.clock_in, .rst_b_in, .cmd_in,
  .cmd_ack_out, .oc_fault_in, .clear_fault_in, .output_enable_out, .fault_latched_out);

// *** ocfr_host.sv ***
// host model: issues command strobes
module ocfr_host (
  input wire logic clock_in,
  output ocfr_pkg::cmd_req_s cmd_out
);
  import ocfr_pkg::*;
  initial cmd_out = '0;
  task automatic xfer(input logic w, input logic [7:0] c, d);
    @(negedge clock_in);
    cmd_out = '{w, !w, c, d};
    @(negedge clock_in);
    cmd_out = '{1'b0, 1'b0, ~c, ~d};
  endtask
endmodule

// *** tb_overcurrent_fault_response.sv ***
// testbench: register access and fault responses
module tb_overcurrent_fault_response;
  timeunit 1ns;
  timeprecision 1ns;
  import ocfr_pkg::*;
  logic clock_in = 0, rst_b_in = 0, oc = 0, en = 1, clr = 0, ack, on, lat;
  cmd_req_s cmd;
  logic [7:0] rd;
  logic [2:0] att;
  logic [8:0] q[$];
  logic [31:0] rng = 32'h404C817D;
  int errors = 0, checked = 0, i;
  localparam int UNIT = 2;
  wire [7:0] st = {lat, on, 3'h0, att};
  always #20 clock_in = ~clock_in;
  ocfr_host ocfr_host_i (.clock_in, .cmd_out(cmd));
  overcurrent_fault_response #(.UNIT_CYC(UNIT), .RESTART_CYC(4)) overcurrent_fault_response_i (
    .clock_in, .rst_b_in, .cmd_in(cmd), .rdata_out(rd), .cmd_ack_out(ack), .oc_fault_in(oc),
    .enable_cmd_in(en), .bias_ok_in(1'b1), .other_fault_in(1'b0), .clear_fault_in(clr),
    .output_enable_out(on), .fault_latched_out(lat), .attempts_out(att));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %0t: %h not %h", $time, s, e);
    end
  endtask
  task results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task hold(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task acc(input logic w, input logic [7:0] c, d);
    if (c == CMD_OC_ACTION) q.push_back({w, d});
    ocfr_host_i.xfer(w, c, d);
  endtask
  task set(input logic [7:0] v);
    acc(1'b1, CMD_OC_ACTION, v);
    oc = 1;
  endtask
  task latch;
    for (i = 0; i < 400 && lat !== 1'b1; i++) hold(1);
    if (i == 400) chk(8'h00, 8'h01);
    if (i == 400) results;
  endtask
  task clear;
    oc = 0;
    hold(3);
    clr = 1;
    hold(1);
    clr = 0;
    hold(3);
  endtask
  // acks are matched in order against the noted accesses
  always @(negedge clock_in) begin
    if (ack === 1'b1 && q.size() == 0) chk(8'h01, 8'h00);
    else if (ack === 1'b1) begin
      if (!q[0][8]) chk(rd, q[0][7:0]);
      q.delete(0);
    end
  end
  initial begin
    hold(20);
    rst_b_in = 1;
    acc(1'b0, CMD_OC_ACTION, OC_ACTION_RESET);
    repeat (4) begin
      rng = lfsr(rng);
      acc(1'b1, CMD_OC_ACTION, rng[7:0]);
      acc(1'b1, 8'h46, 8'h00);
      acc(1'b0, 8'h46, 8'h00);
      chk(rd, 8'h00);
      acc(1'b0, CMD_OC_ACTION, rng[7:0]);
    end
    $display("register test done");
    set(8'h88);
    latch;
    chk(st, 8'h81);
    clear;
    chk(st, 8'h40);
    set(8'hC0);
    hold(6);
    chk(st, 8'h00);
    oc = 0;
    hold(6);
    chk(st, 8'h40);
    set(8'h00);
    hold(20);
    chk(st, 8'h40);
    clear;
    set(8'h42);
    hold(5);
    chk(st, 8'h40);
    latch;
    chk(8'(i), 8'(4 * UNIT - 1));
    chk(st, 8'h80);
    clear;
    $display("response test done");
    set(8'hB8);
    hold(30);
    chk({7'h0, lat}, 8'h00);
    en = 0;
    latch;
    chk(st, 8'h80);
    en = 1;
    clear;
    $display("retry test done");
    results;
  end
endmodule
